// >>> hdl/rsm_deglitch.v
// Rising-edge deglitch filter for the external reset pin.
module rsm_deglitch #(
    parameter CYCLES = 17500
) (
    input wire clk_sys,
    input wire rawRst_n,
    input wire pinSync,
    output reg clean_q
);
    reg [31:0] count_q;
    // A low level resets the filter at once; a high must persist before release.
    always @(posedge clk_sys or negedge rawRst_n)
    begin
        if (!rawRst_n)
        begin
            count_q <= 32'h0;
            clean_q <= 1'b0;
        end
        else if (!pinSync)
        begin
            count_q <= 32'h0;
            clean_q <= 1'b0;
        end
        else if (count_q >= CYCLES - 1)
            clean_q <= 1'b1;
        else
            count_q <= count_q + 32'h1;
    end
endmodule

// >>> hdl/rsm_state_ctrl.v
// Operating-state controller of the resolver converter with its APB register file.
`include "rsm_regs.vh"
module rsm_state_ctrl #(
    parameter DEGLITCH_CYCLES = (`RSM_DEGLITCH_NS + `RSM_CLK_PERIOD_NS - 1) / `RSM_CLK_PERIOD_NS,
    parameter CLEAR_LOW_MAX_CYCLES = `RSM_CLEAR_LOW_MAX_NS / `RSM_CLK_PERIOD_NS,
    parameter BLANK_CYCLES = `RSM_BLANK_MS * 1000000 / `RSM_CLK_PERIOD_NS
) (
    input wire clk_sys,
    input wire rst_n,
    input wire externalResetPin_n,
    input wire faultClearPin,
    input wire supplyUv,
    input wire coreRegUv,
    input wire clockLoss,
    input wire thermalShutdown,
    input wire [`RSM_NFAULT-1:0] faultIn,
    input wire checksDone,
    input wire [11:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    output reg boostEnable_q,
    output reg coreRegEnable_q,
    output reg frontEndEnable_q,
    output reg oscEnable_q,
    output reg exciterEnable_q,
    output reg loopEnable_q,
    output reg monitorEnable_q,
    output reg runChecks_q,
    output reg outputsValid_q,
    output wire faultPinOut,
    output wire faultPinOe
);
    // Fault bit order of faultIn: 0 cal, 1 overcurrent, 2 thermal warn, 3 user crc,
    // 4 trim crc, 5 serial, 6 exciter uv, 7 input high ov, 8 input low ov, 9 short,
    // 10-13 open faults, 14 loop error, 15 analog self-test, 16 logic self-test,
    // 17 pin readback; higher bits unused beyond these.
    localparam [1:0] ST_DIAG = `RSM_STATE_DIAG;
    localparam [1:0] ST_NORMAL = `RSM_STATE_NORMAL;
    localparam [1:0] ST_FAULT = `RSM_STATE_FAULT;
    localparam [`RSM_NFAULT-1:0] KEEP_ON = 18'h0003f;
    localparam [`RSM_NFAULT-1:0] GRP_UV = 18'h00040;
    localparam [`RSM_NFAULT-1:0] GRP_INPUT = 18'h03f80;
    localparam [`RSM_NFAULT-1:0] GRP_LOOP = 18'h04000;
    localparam [`RSM_NFAULT-1:0] GRP_BIST = 18'h18000;
    localparam [`RSM_NFAULT-1:0] GRP_PIN = 18'h20000;

    wire pinRstSync;
    wire clearSync;
    wire pinClean;
    reg [1:0] sysRst_q;
    wire sysRst_n;
    wire severe;
    wire porRst_n;
    reg [1:0] por_q;

    // Reset pin and fault-clear pin come from outside and are synchronised first.
    rsm_sync uRstSync (
        .clk_sys(clk_sys),
        .rst_n(sysRst_n),
        .din(externalResetPin_n),
        .dout_q(pinRstSync)
    );
    rsm_sync uClrSync (
        .clk_sys(clk_sys),
        .rst_n(sysRst_n),
        .din(faultClearPin),
        .dout_q(clearSync)
    );
    rsm_deglitch #(
        .CYCLES(DEGLITCH_CYCLES)
    ) uDeglitch (
        .clk_sys(clk_sys),
        .rawRst_n(sysRst_n),
        .pinSync(pinRstSync),
        .clean_q(pinClean)
    );

    // Board reset released through two flip-flops.
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            sysRst_q <= 2'h0;
        else
            sysRst_q <= {sysRst_q[0], 1'b1};
    end
    assign sysRst_n = sysRst_q[1];

    // Internal power-on reset: held by a low pin or a severe condition.
    reg [3:0] severeMeta_q;
    reg [3:0] severeSync_q;
    // Monitor levels come from analog comparators, so they cross two flip-flops first.
    // The two cycles of latency are traded for freedom from metastable resets.
    always @(posedge clk_sys or negedge sysRst_n)
    begin
        if (!sysRst_n)
        begin
            severeMeta_q <= 4'h0;
            severeSync_q <= 4'h0;
        end
        else
        begin
            severeMeta_q <= {supplyUv, coreRegUv, clockLoss, thermalShutdown};
            severeSync_q <= severeMeta_q;
        end
    end
    assign severe = |severeSync_q;
    always @(posedge clk_sys or negedge sysRst_n)
    begin
        if (!sysRst_n)
            por_q <= 2'h0;
        else if (!pinClean || severe)
            por_q <= 2'h0;
        else
            por_q <= {por_q[0], 1'b1};
    end
    assign porRst_n = por_q[1];

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg diag_exit_request_q;
    reg diagReq_q;
    reg [4:0] override_q;
    reg [`RSM_NFAULT-1:0] mask_q;
    reg [`RSM_NFAULT-1:0] flags_q;
    reg [1:0] seq_q;
    reg clearPrev_q;
    reg [31:0] lowCount_q;
    reg [31:0] blank_q;
    reg reentry_q;

    wire [`RSM_NFAULT-1:0] active = faultIn & ~mask_q;
    wire anyFault = |active;
    wire [`RSM_NFAULT-1:0] excOk = KEEP_ON
        | (override_q[`RSM_OVR_EXC_UV] ? GRP_UV : 18'h0)
        | (override_q[`RSM_OVR_INPUT] ? GRP_INPUT : 18'h0)
        | (override_q[`RSM_OVR_LOOP] ? GRP_LOOP : 18'h0)
        | (override_q[`RSM_OVR_SELFTEST] ? GRP_BIST : 18'h0)
        | (override_q[`RSM_OVR_PIN] ? GRP_PIN : 18'h0);
    wire excKill = |(active & ~excOk);
    // A pulse is accepted only if the low phase stayed within the limit.
    wire clearPulse = clearSync & ~clearPrev_q && lowCount_q <= CLEAR_LOW_MAX_CYCLES;

    wire apbWrite = psel & penable & pwrite;
    wire apbRead = psel & penable & ~pwrite;
    wire wrCtrl1 = apbWrite && paddr == `RSM_ADDR_CTRL1;
    wire wrCtrl3 = apbWrite && paddr == `RSM_ADDR_CTRL3;
    wire rdFlags = apbRead && paddr == `RSM_ADDR_FLAGS;

    // Next-state logic.
    always @*
    begin
        state_d = state_q;
        case (state_q)
            ST_DIAG:
                if (diag_exit_request_q)
                    state_d = ST_NORMAL;
                else if (checksDone && !anyFault)
                    state_d = ST_NORMAL;
            ST_NORMAL:
                if (diagReq_q)
                    state_d = ST_DIAG;
                else if (anyFault)
                    state_d = ST_FAULT;
            ST_FAULT:
                if (clearPulse)
                    state_d = ST_NORMAL;
            default:
                state_d = ST_DIAG;
        endcase
    end

    // Main state, enables, control bits and flags; reset restores the frozen condition.
    always @(posedge clk_sys or negedge porRst_n)
    begin
        if (!porRst_n)
        begin
            state_q <= ST_DIAG;
            boostEnable_q <= 1'b0;
            coreRegEnable_q <= 1'b0;
            frontEndEnable_q <= 1'b0;
            oscEnable_q <= 1'b0;
            exciterEnable_q <= 1'b0;
            loopEnable_q <= 1'b0;
            monitorEnable_q <= 1'b0;
            runChecks_q <= 1'b0;
            outputsValid_q <= 1'b0;
            diag_exit_request_q <= 1'b0;
            diagReq_q <= 1'b0;
            override_q <= 5'h0;
            mask_q <= 18'h0;
            flags_q <= 18'h0;
            seq_q <= 2'h0;
            clearPrev_q <= 1'b1;
            lowCount_q <= 32'h0;
            blank_q <= 32'h0;
            reentry_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            boostEnable_q <= 1'b1;
            coreRegEnable_q <= 1'b1;
            frontEndEnable_q <= 1'b1;
            oscEnable_q <= 1'b1;
            clearPrev_q <= clearSync;
            lowCount_q <= clearSync ? 32'h0 : lowCount_q + 32'h1;
            if (blank_q < BLANK_CYCLES)
                blank_q <= blank_q + 32'h1;
            // Flags are sticky; a read clears only those whose cause is gone, so set wins.
            flags_q <= (rdFlags ? 18'h0 : flags_q) | faultIn;
            if (wrCtrl1 && pwdata[`RSM_CTRL1_DIAG_EXIT])
                diag_exit_request_q <= 1'b1;
            if (wrCtrl3 && pwdata[`RSM_CTRL3_DIAG_REENTRY])
                diagReq_q <= 1'b1;
            if (apbWrite && paddr == `RSM_ADDR_OVERRIDE)
                override_q <= pwdata[4:0];
            if (apbWrite && paddr == `RSM_ADDR_MASK)
                mask_q <= pwdata[`RSM_NFAULT-1:0];
            case (state_d)
                ST_DIAG:
                begin
                    runChecks_q <= 1'b1;
                    // Dropped on entry only, so a host re-enable after reentry is kept.
                    if (state_q != ST_DIAG)
                    begin
                        exciterEnable_q <= 1'b0;
                        loopEnable_q <= 1'b0;
                    end
                    monitorEnable_q <= 1'b0;
                    outputsValid_q <= 1'b0;
                    seq_q <= 2'h0;
                    if (state_q == ST_NORMAL)
                    begin
                        diagReq_q <= 1'b0;
                        reentry_q <= blank_q >= BLANK_CYCLES;
                    end
                    if (state_q == ST_DIAG && reentry_q && wrCtrl3)
                    begin
                        exciterEnable_q <= pwdata[`RSM_CTRL3_EXC_EN];
                        loopEnable_q <= pwdata[`RSM_CTRL3_LOOP_EN];
                    end
                end
                ST_NORMAL:
                begin
                    runChecks_q <= 1'b0;
                    diag_exit_request_q <= 1'b0;
                    reentry_q <= 1'b0;
                    // Blocks come up one per cycle in the documented order.
                    if (seq_q != 2'h3)
                        seq_q <= seq_q + 2'h1;
                    if (seq_q == 2'h0)
                        exciterEnable_q <= 1'b1;
                    if (seq_q == 2'h1)
                        loopEnable_q <= 1'b1;
                    if (seq_q == 2'h2)
                        monitorEnable_q <= 1'b1;
                    if (seq_q == 2'h3 && wrCtrl3)
                    begin
                        exciterEnable_q <= pwdata[`RSM_CTRL3_EXC_EN];
                        loopEnable_q <= pwdata[`RSM_CTRL3_LOOP_EN];
                    end
                    outputsValid_q <= exciterEnable_q & loopEnable_q & monitorEnable_q;
                end
                ST_FAULT:
                begin
                    runChecks_q <= 1'b0;
                    loopEnable_q <= 1'b0;
                    outputsValid_q <= 1'b0;
                    // Restart the bring-up order so a cleared fault brings the loop back.
                    seq_q <= 2'h0;
                    if (excKill)
                        exciterEnable_q <= 1'b0;
                    else if (wrCtrl3)
                        exciterEnable_q <= pwdata[`RSM_CTRL3_EXC_EN];
                end
                default:
                    runChecks_q <= 1'b0;
            endcase
        end
    end

    // Open drain: driven low when no fault and in reset freeze, released only in the fault state.
    assign faultPinOut = 1'b0;
    assign faultPinOe = (state_q != ST_FAULT) | ~porRst_n;

    // Read mux; unmapped addresses read zero and raise no error.
    reg [31:0] rdata;
    always @*
    begin
        rdata = 32'h0;
        case (paddr)
            `RSM_ADDR_STATUS:
                rdata = {30'h0, porRst_n ? state_q : 2'h0};
            `RSM_ADDR_CTRL1:
                rdata = {31'h0, diag_exit_request_q};
            `RSM_ADDR_CTRL3:
                rdata = {29'h0, loopEnable_q, exciterEnable_q, diagReq_q};
            `RSM_ADDR_OVERRIDE:
                rdata = {27'h0, override_q};
            `RSM_ADDR_MASK:
                rdata = {14'h0, mask_q};
            `RSM_ADDR_FLAGS:
                rdata = {14'h0, flags_q};
            `RSM_ADDR_CHECKS:
                rdata = {30'h0, checksDone, runChecks_q};
            default:
                rdata = 32'h0;
        endcase
    end
    assign prdata = (psel & ~pwrite) ? rdata : 32'h0;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
endmodule

// >>> hdl/rsm_sync.v
// Two flip-flop synchroniser for one level.
module rsm_sync (
    input wire clk_sys,
    input wire rst_n,
    input wire din,
    output reg dout_q
);
    reg meta_q;
    // The first stage feeds only the second stage.
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= 1'b0;
            dout_q <= 1'b0;
        end
        else
        begin
            meta_q <= din;
            dout_q <= meta_q;
        end
    end
endmodule

// >>> pkg/rsm_regs.vh
// Register offsets, field positions, state codes and timing constants of the state controller.
`ifndef RSM_REGS_VH
`define RSM_REGS_VH
`define RSM_ADDR_STATUS 12'h000
`define RSM_ADDR_CTRL1 12'h004
`define RSM_ADDR_CTRL3 12'h008
`define RSM_ADDR_OVERRIDE 12'h00c
`define RSM_ADDR_MASK 12'h010
`define RSM_ADDR_FLAGS 12'h014
`define RSM_ADDR_CHECKS 12'h018
`define RSM_STATE_DIAG 2'h1
`define RSM_STATE_NORMAL 2'h2
`define RSM_STATE_FAULT 2'h3
`define RSM_CTRL1_DIAG_EXIT 0
`define RSM_CTRL3_DIAG_REENTRY 0
`define RSM_CTRL3_EXC_EN 1
`define RSM_CTRL3_LOOP_EN 2
`define RSM_OVR_EXC_UV 0
`define RSM_OVR_INPUT 1
`define RSM_OVR_LOOP 2
`define RSM_OVR_SELFTEST 3
`define RSM_OVR_PIN 4
`define RSM_NFAULT 18
`define RSM_DEGLITCH_NS 70000
`define RSM_CLK_PERIOD_NS 4
`define RSM_CLEAR_LOW_MAX_NS 1000000
`define RSM_BLANK_MS 150
`endif

// >>> tb/rsm_host_pins.sv
// Host pin model: fault-line pull-up and fault-clear pulse generator.
module rsm_host_pins (
    input logic clk_sys,
    input logic faultPinOut,
    input logic faultPinOe,
    input logic clearGo,
    input logic [7:0] lowLen,
    output logic faultClearPin = 1'b1,
    output logic faultPinLevel
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] lowCnt_q = 8'h0;
    // The board pull-up lifts the line whenever the device lets go of it.
    assign faultPinLevel = faultPinOe ? faultPinOut : 1'b1;
    // One high-low-high pulse per request; the caller picks the low time.
    always @(posedge clk_sys)
    begin
        if (clearGo && lowCnt_q == 8'h0)
        begin
            faultClearPin <= 1'b0;
            lowCnt_q <= lowLen;
        end
        else if (lowCnt_q > 8'h1)
            lowCnt_q <= lowCnt_q - 8'h1;
        else
        begin
            faultClearPin <= 1'b1;
            lowCnt_q <= 8'h0;
        end
    end
endmodule

// >>> tb/rsm_state_ctrl_checker.sv
// Concurrent checks on the operating-state controller ports.
`include "rsm_regs.vh"
module rsm_state_ctrl_checker (
    input logic clk_sys,
    input logic rst_n,
    input logic externalResetPin_n,
    input logic supplyUv,
    input logic [`RSM_NFAULT-1:0] faultIn,
    input logic boostEnable_q,
    input logic coreRegEnable_q,
    input logic exciterEnable_q,
    input logic loopEnable_q,
    input logic monitorEnable_q,
    input logic runChecks_q,
    input logic outputsValid_q,
    input logic faultPinOut,
    input logic faultPinOe
);
    timeunit 1ns;
    timeprecision 1ps;
    // One clock domain, so the board reset disables every check.
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    a_pin_reset_off: assert property (!externalResetPin_n [*6] |->
        !boostEnable_q && !exciterEnable_q && faultPinOe) else $error("Active in pin reset.");
    a_severe_off: assert property (supplyUv [*5] |->
        !coreRegEnable_q && !loopEnable_q && faultPinOe) else $error("Active in undervolt.");
    a_deglitch_wait: assert property ($rose(boostEnable_q) |->
        $past(externalResetPin_n, 8)) else $error("Reset pin not filtered.");
    a_diag_quiet: assert property (runChecks_q [*2] |-> boostEnable_q &&
        coreRegEnable_q && !monitorEnable_q && !outputsValid_q && faultPinOe)
        else $error("Diagnostics outputs wrong.");
    a_enable_order: assert property ($rose(monitorEnable_q) |->
        $past(loopEnable_q) && $past(exciterEnable_q, 2)) else $error("Enable order wrong.");
    a_fault_frozen: assert property (!faultPinOe [*2] |->
        !loopEnable_q && !outputsValid_q) else $error("Loop runs in fault state.");
    a_soft_keep_exc: assert property ($fell(faultPinOe) && faultIn[5:0] != 6'h0 &&
        faultIn[17:6] == 12'h0 && $past(exciterEnable_q) |-> exciterEnable_q)
        else $error("Exciter dropped on soft fault.");
    a_pin_drain: assert property (faultPinOe |-> !faultPinOut)
        else $error("Fault pin driven high.");
endmodule
bind rsm_state_ctrl rsm_state_ctrl_checker i_chk (.clk_sys(clk_sys), .rst_n(rst_n),
    .externalResetPin_n(externalResetPin_n), .supplyUv(supplyUv), .faultIn(faultIn),
    .boostEnable_q(boostEnable_q), .coreRegEnable_q(coreRegEnable_q),
    .exciterEnable_q(exciterEnable_q), .loopEnable_q(loopEnable_q),
    .monitorEnable_q(monitorEnable_q), .runChecks_q(runChecks_q),
    .outputsValid_q(outputsValid_q), .faultPinOut(faultPinOut), .faultPinOe(faultPinOe));

// >>> tb/tb_top.sv
// Self-checking testbench of the operating-state controller.
`include "rsm_regs.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic extRst_n = 1'b1;
    logic checksDone = 1'b0;
    logic clearGo = 1'b0;
    logic [3:0] severe = 4'h0;
    logic [`RSM_NFAULT-1:0] faultIn = '0;
    logic [11:0] paddr = 12'h0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [7:0] lowLen = 8'h0;
    logic [31:0] prdata, rd;
    logic pready, boostEn, coreEn, excEn, loopEn, monEn, runChk, valid, pinOut, pinOe;
    logic clearPin, pinLevel, feEn, oscEn;
    int errors = 0;
    int compares = 0;
    int cycles = 0;
    int n;
    rsm_state_ctrl #(.DEGLITCH_CYCLES(8), .CLEAR_LOW_MAX_CYCLES(50), .BLANK_CYCLES(100)) i_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .externalResetPin_n(extRst_n),
        .faultClearPin(clearPin), .supplyUv(severe[0]), .coreRegUv(severe[1]),
        .clockLoss(severe[2]), .thermalShutdown(severe[3]), .faultIn(faultIn),
        .checksDone(checksDone), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(),
        .boostEnable_q(boostEn), .coreRegEnable_q(coreEn), .frontEndEnable_q(feEn),
        .oscEnable_q(oscEn), .exciterEnable_q(excEn), .loopEnable_q(loopEn),
        .monitorEnable_q(monEn), .runChecks_q(runChk), .outputsValid_q(valid),
        .faultPinOut(pinOut), .faultPinOe(pinOe));
    rsm_host_pins i_host (.clk_sys(clk_sys), .faultPinOut(pinOut), .faultPinOe(pinOe),
        .clearGo(clearGo), .lowLen(lowLen), .faultClearPin(clearPin), .faultPinLevel(pinLevel));
    task automatic finish_test();
        $display("Compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Free-running clock; a hung wait is cut short and counted as a mismatch.
    initial forever #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            errors++;
            finish_test();
        end
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e)
        begin
            errors++;
            $display("Error %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    // APB transfer; read data is taken in the access cycle that pready completes.
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1)
            @(posedge clk_sys);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        apb(a, 1'b0, 32'h0);
        chk(rd, e);
    endtask
    task automatic wait_hi(input logic isValid);
        n = 0;
        while ((isValid ? valid : boostEn) !== 1'b1 && n < 100)
        begin
            @(posedge clk_sys);
            n++;
        end
    endtask
    task automatic pulse(input logic [7:0] len);
        lowLen <= len;
        clearGo <= 1'b1;
        @(posedge clk_sys);
        clearGo <= 1'b0;
        repeat (len + 12) @(posedge clk_sys);
    endtask
    // Power-up: frozen while the pin is filtered, then diagnostics with checks running.
    task automatic t_reset();
        chk({boostEn, feEn, oscEn, excEn, monEn, pinOe}, 32'h1);
        apb(`RSM_ADDR_MASK, 1'b1, 32'h3ffff);
        rdc(`RSM_ADDR_STATUS, 32'h0);
        wait_hi(1'b0);
        rdc(`RSM_ADDR_STATUS, `RSM_STATE_DIAG);
        rdc(`RSM_ADDR_MASK, 32'h0);
        rdc(`RSM_ADDR_CHECKS, 32'h1);
        chk({coreEn, feEn, oscEn, excEn, loopEn, monEn, pinLevel}, 32'h70);
    endtask
    // Checks end with a fault: locked until the host forces the exit.
    task automatic t_lock();
        faultIn[9] <= 1'b1;
        checksDone <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rdc(`RSM_ADDR_STATUS, `RSM_STATE_DIAG);
        checksDone <= 1'b0;
        apb(`RSM_ADDR_MASK, 1'b1, 32'h200);
        apb(`RSM_ADDR_CTRL1, 1'b1, 32'h1);
        wait_hi(1'b1);
        rdc(`RSM_ADDR_STATUS, `RSM_STATE_NORMAL);
        rdc(`RSM_ADDR_CTRL1, 32'h0);
        rdc(`RSM_ADDR_FLAGS, 32'h200);
        chk({excEn, loopEn, monEn, pinLevel}, 32'he);
        faultIn <= '0;
        apb(`RSM_ADDR_MASK, 1'b1, 32'h0);
        rdc(`RSM_ADDR_FLAGS, 32'h200);
        rdc(`RSM_ADDR_FLAGS, 32'h0);
    endtask
    // Each fault class: fault state, exciter kept or dropped, then a clear pulse.
    task automatic t_faults();
        int fb[9] = '{0, 5, 9, 9, 6, 14, 16, 17, 10};
        int ov[9] = '{0, 0, 0, 2, 1, 4, 8, 16, 0};
        logic [8:0] ex = 9'h0fb;
        for (int i = 0; i < 9; i++)
        begin
            apb(`RSM_ADDR_OVERRIDE, 1'b1, ov[i]);
            faultIn[fb[i]] <= 1'b1;
            repeat (3) @(posedge clk_sys);
            rdc(`RSM_ADDR_STATUS, `RSM_STATE_FAULT);
            chk({pinLevel, loopEn, valid, excEn}, {3'b100, ex[i]});
            faultIn <= '0;
            pulse(8'h0a);
            rdc(`RSM_ADDR_STATUS, `RSM_STATE_NORMAL);
            chk({excEn, loopEn, monEn}, 32'h7);
            rdc(`RSM_ADDR_FLAGS, 32'h1 << fb[i]);
        end
        faultIn[5] <= 1'b1;
        repeat (3) @(posedge clk_sys);
        faultIn <= '0;
        pulse(8'h3c);
        rdc(`RSM_ADDR_STATUS, `RSM_STATE_FAULT);
        pulse(8'h0a);
        rdc(`RSM_ADDR_STATUS, `RSM_STATE_NORMAL);
    endtask
    // Host-commanded return to diagnostics after the blanking time.
    task automatic t_reentry();
        checksDone <= 1'b0;
        repeat (120) @(posedge clk_sys);
        apb(`RSM_ADDR_CTRL3, 1'b1, 32'h7);
        rdc(`RSM_ADDR_STATUS, `RSM_STATE_DIAG);
        rdc(`RSM_ADDR_CTRL3, 32'h0);
        chk({runChk, excEn, loopEn}, 32'h4);
        apb(`RSM_ADDR_CTRL3, 1'b1, 32'h6);
        rdc(`RSM_ADDR_CTRL3, 32'h6);
        chk({excEn, loopEn}, 32'h3);
        apb(`RSM_ADDR_CTRL3, 1'b1, 32'h0);
        chk(excEn, 32'h0);
        checksDone <= 1'b1;
        wait_hi(1'b1);
        rdc(`RSM_ADDR_STATUS, `RSM_STATE_NORMAL);
    endtask
    // Supply, clock, thermal and pin resets each freeze the block until removed.
    task automatic t_severe();
        for (int i = 0; i < 5; i++)
        begin
            checksDone <= 1'b0;
            if (i < 4)
                severe[i] <= 1'b1;
            else
                extRst_n <= 1'b0;
            repeat (8) @(posedge clk_sys);
            chk({boostEn, coreEn, feEn, oscEn, excEn, monEn, pinLevel}, 32'h0);
            rdc(`RSM_ADDR_STATUS, 32'h0);
            severe <= 4'h0;
            extRst_n <= 1'b1;
            wait_hi(1'b0);
            chk(n >= (i < 4 ? 2 : 10), 32'h1);
            rdc(`RSM_ADDR_STATUS, `RSM_STATE_DIAG);
        end
        checksDone <= 1'b1;
        apb(12'h01c, 1'b1, 32'hffffffff);
        rdc(12'h01c, 32'h0);
        apb(`RSM_ADDR_STATUS, 1'b1, 32'h0);
        wait_hi(1'b1);
        rdc(`RSM_ADDR_STATUS, `RSM_STATE_NORMAL);
    endtask
    // Main sequence: board reset for eight cycles, then every scenario in turn.
    initial
    begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        t_reset();
        t_lock();
        t_faults();
        t_reentry();
        t_severe();
        finish_test();
    end
endmodule
